/* File: design/flash_page_program_protect.sv */
/*
 * Page program, margin read and block protection control for a
 * two-array flash. Assumes the macro returns mac_rdata combinationally
 * for mac_addr, and that software performs every timed wait itself.
 */
`timescale 1ns/1ns
module flash_page_program_protect #(
	parameter int STRETCH_CYCLES = flash_prot_pkg::STRETCH_DEFAULT
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// cpu access to the arrays
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	output logic [7:0] cpu_rdata,
	output logic cpu_rvalid,
	output logic cpu_busy,
	// flash macro read side
	output logic [15:0] mac_addr,
	output logic mac_margin,
	input wire logic [7:0] mac_rdata,
	// pins and power modes
	input wire logic high_test_voltage,
	input wire logic wait_mode,
	input wire logic stop_mode,
	// per-array macro control
	output flash_prot_pkg::array_drive_type upper_drive,
	output flash_prot_pkg::array_drive_type lower_drive
);
	import flash_prot_pkg::*;

	rd_state_type state_r;
	logic [3:0] cnt_r;
	logic [15:0] mac_addr_r;
	logic mac_margin_r;
	logic rd_arr_r;
	logic [7:0] cpu_rdata_r;
	logic cpu_rvalid_r;
	logic cpu_busy_r;
	logic [7:0] reg_rdata_r;
	logic rd_done;
	logic [NUM_ARRAYS-1:0] margin_ok_v;
	logic [NUM_ARRAYS-1:0] prot_read_v;
	logic [NUM_ARRAYS-1:0] verify_v;
	logic [NUM_ARRAYS-1:0] parked_v;
	logic [NUM_ARRAYS-1:0][7:0] ctrl_v;
	logic [NUM_ARRAYS-1:0][7:0] prot_v;
	array_drive_type [NUM_ARRAYS-1:0] drive_v;

	// lowest programmed bit gives the lowest start, so it wins the union
	function automatic logic [16:0] lock_start(input logic [7:0] p,
		input logic [3:0][15:0] tbl);
		logic [16:0] s;
		s = NO_LOCK;
		for (int i = 3; i >= 0; i--) begin
			if (p[i]) begin
				s = {1'b0, tbl[i]};
			end
		end
		return s;
	endfunction

	// the read completes in the fetch cycle or in the last stretch cycle
	assign rd_done = (state_r == RD_FETCH && !mac_margin_r) ||
		(state_r == RD_STRETCH && cnt_r == 4'(STRETCH_CYCLES - 1));

	genvar a;
	generate
		for (a = 0; a < NUM_ARRAYS; a++) begin : g_arr
			localparam logic [2:0] CTRL_OFS = (a == ARR_UPPER) ? REG_CTRL_UPPER : REG_CTRL_LOWER;
			localparam logic [15:0] PROT_ADDR = (a == ARR_UPPER) ? PROT_ADDR_UPPER : PROT_ADDR_LOWER;
			localparam logic [3:0][15:0] TBL = (a == ARR_UPPER) ? UPPER_LOCK : LOWER_LOCK;
			logic prog_r, erase_r, high_voltage_enable_r, margin_r;
			logic verify_ok_r, prot_read_r, target_ok_r, parked_r;
			logic pump_r, standby_r;
			logic [1:0] blk_r, fdiv_r;
			logic [15:0] target_r;
			logic [7:0] prot_r, mask_r;
			logic [63:0] data_r;
			logic ctrl_wr, in_array, arr_wr, prot_cap;
			logic wp, we, prog_nxt, erase_nxt, high_voltage_enable_nxt, margin_nxt, sel_rise, sel_drop;
			logic [15:0] span_mask, span_lo, span_hi;
			logic lock_hit, prot_hit, violation;

			assign ctrl_wr = reg_wr && reg_addr == CTRL_OFS;
			// the lower protect byte sits at the top of the upper array
			// upper control owns it
			assign in_array = (a == ARR_UPPER) ? cpu_addr[15] : !cpu_addr[15];
			assign arr_wr = cpu_wr && in_array && !high_voltage_enable_r && (prog_r || erase_r);
			assign prot_cap = rd_done && mac_addr_r == PROT_ADDR;

			assign wp = reg_wdata[BIT_PROG];
			assign we = reg_wdata[BIT_ERASE];
			assign prog_nxt = (wp && we) ? prog_r : wp;
			assign erase_nxt = (wp && we) ? erase_r : we;
			assign high_voltage_enable_nxt = reg_wdata[BIT_HIGH_VOLTAGE_ENABLE] && (prog_nxt || erase_nxt) &&
				(high_voltage_enable_r || (prot_read_r && target_ok_r));
			assign margin_nxt = reg_wdata[BIT_MARGIN] && !high_voltage_enable_nxt;
			assign sel_rise = ctrl_wr && (prog_nxt || erase_nxt) && !(prog_r || erase_r);
			assign sel_drop = ctrl_wr && !(prog_nxt || erase_nxt);

			// a program spans one aligned page
			assign span_mask = prog_r ? PAGE_MASK : BLK_MASK[blk_r];
			assign span_lo = target_r & ~span_mask;
			assign span_hi = target_r | span_mask;
			assign lock_hit = {1'b0, span_hi} >= lock_start(prot_r, TBL);
			assign prot_hit = (a == ARR_UPPER) && span_hi >= PROT_ADDR_UPPER &&
				span_lo <= PROT_ADDR_LOWER;
			// test voltage bypasses the check
			// only a live select is judged, so a cleared operation is not re-checked
			assign violation = (prog_r || erase_r) && target_ok_r && prot_read_r &&
				!high_test_voltage && (lock_hit || prot_hit);

			// control bits; a protection hit overrides a select or high voltage write that cycle
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					prog_r <= CTRL_RESET[BIT_PROG];
					erase_r <= CTRL_RESET[BIT_ERASE];
					high_voltage_enable_r <= CTRL_RESET[BIT_HIGH_VOLTAGE_ENABLE];
					margin_r <= CTRL_RESET[BIT_MARGIN];
					blk_r <= CTRL_RESET[BIT_BLK +: 2];
					fdiv_r <= CTRL_RESET[BIT_FDIV +: 2];
				end else if (clk_en) begin
					if (violation) begin
						prog_r <= 1'b0;
						erase_r <= 1'b0;
						high_voltage_enable_r <= 1'b0;
					end else if (ctrl_wr) begin
						prog_r <= prog_nxt;
						erase_r <= erase_nxt;
						high_voltage_enable_r <= high_voltage_enable_nxt;
					end
					if (ctrl_wr) begin
						margin_r <= margin_nxt;
						blk_r <= reg_wdata[BIT_BLK +: 2];
						fdiv_r <= reg_wdata[BIT_FDIV +: 2];
					end
				end
			end

			// operation context: protect latch and captured target
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					prot_read_r <= 1'b0;
					prot_r <= 8'h00;
					target_ok_r <= 1'b0;
					target_r <= PROT_ADDR_INIT;
					mask_r <= 8'h00;
					data_r <= 64'h0;
				end else if (clk_en) begin
					// a refused operation needs a fresh protect read before high voltage
					if (sel_rise || sel_drop || violation) begin
						prot_read_r <= 1'b0;
						target_ok_r <= 1'b0;
						mask_r <= 8'h00;
					end
					if (prot_cap) begin
						prot_r <= mac_rdata;
						prot_read_r <= prog_r || erase_r;
					end
					if (arr_wr && !target_ok_r) begin
						target_r <= cpu_addr;
						target_ok_r <= 1'b1;
					end
					if (arr_wr && prog_r && (!target_ok_r ||
						(cpu_addr & ~PAGE_MASK) == span_lo)) begin
						data_r[cpu_addr[2:0]*PAGE_BYTES +: PAGE_BYTES] <= cpu_wdata;
						mask_r[cpu_addr[2:0]] <= 1'b1;
					end
				end
			end

			// verify allowed once a program pulse ended
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					verify_ok_r <= 1'b0;
				end else if (clk_en) begin
					if (ctrl_wr && high_voltage_enable_r && !high_voltage_enable_nxt && prog_r) begin
						verify_ok_r <= 1'b1;
					end else if (sel_rise || (ctrl_wr && !margin_nxt)) begin
						verify_ok_r <= 1'b0;
					end
				end
			end

			// pump and standby; a parked operation waits for reset, since an
			// interrupt vector could not be fetched from a non-read array
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					parked_r <= 1'b0;
					pump_r <= 1'b0;
					standby_r <= 1'b0;
				end else if (clk_en) begin
					// pump off in wait or stop
					if ((wait_mode || stop_mode) && high_voltage_enable_r) begin
						parked_r <= 1'b1;
					end
					pump_r <= high_voltage_enable_r && !wait_mode && !stop_mode && !parked_r;
					// stop in read mode is standby
					standby_r <= stop_mode && !prog_r && !erase_r;
				end
			end

			assign margin_ok_v[a] = margin_r && verify_ok_r;
			assign prot_read_v[a] = prot_read_r;
			assign verify_v[a] = verify_ok_r;
			assign parked_v[a] = parked_r;
			assign prot_v[a] = prot_r;
			assign ctrl_v[a] = {fdiv_r, blk_r, high_voltage_enable_r, margin_r, erase_r, prog_r};
			assign drive_v[a] = '{pump_on: pump_r, prog: prog_r, erase: erase_r,
				margin: margin_r, standby: standby_r, blk: blk_r, fdiv: fdiv_r,
				target_addr: target_r, page_mask: mask_r, page_data: data_r};
		end
	endgenerate

	// array read sequencer; new reads are ignored while one is busy
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r <= RD_IDLE;
			cnt_r <= 4'h0;
			mac_addr_r <= PROT_ADDR_INIT;
			mac_margin_r <= 1'b0;
			rd_arr_r <= 1'b0;
			cpu_busy_r <= 1'b0;
		end else if (clk_en) begin
			case (state_r)
				RD_IDLE: begin
					if (cpu_rd) begin
						mac_addr_r <= cpu_addr;
						rd_arr_r <= !cpu_addr[15];
						mac_margin_r <= margin_ok_v[!cpu_addr[15]];
						cpu_busy_r <= 1'b1;
						state_r <= RD_FETCH;
					end
				end
				RD_FETCH: begin
					cnt_r <= 4'h0;
					if (mac_margin_r) begin
						state_r <= RD_STRETCH;
					end else begin
						cpu_busy_r <= 1'b0;
						state_r <= RD_IDLE;
					end
				end
				RD_STRETCH: begin
					cnt_r <= cnt_r + 4'h1;
					if (rd_done) begin
						cpu_busy_r <= 1'b0;
						mac_margin_r <= 1'b0;
						state_r <= RD_IDLE;
					end
				end
				default: begin
					state_r <= RD_IDLE;
				end
			endcase
		end
	end

	// read data straight from the cells, erased reads as zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cpu_rdata_r <= 8'h00;
			cpu_rvalid_r <= 1'b0;
		end else if (clk_en) begin
			cpu_rvalid_r <= rd_done;
			if (rd_done) begin
				cpu_rdata_r <= mac_rdata;
			end
		end
	end

	// register read port, data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata_r <= 8'h00;
		end else if (clk_en) begin
			reg_rdata_r <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					REG_CTRL_UPPER: reg_rdata_r <= ctrl_v[ARR_UPPER];
					REG_CTRL_LOWER: reg_rdata_r <= ctrl_v[ARR_LOWER];
					REG_PROT_UPPER: reg_rdata_r <= prot_v[ARR_UPPER];
					REG_PROT_LOWER: reg_rdata_r <= prot_v[ARR_LOWER];
					REG_STATUS: begin
						reg_rdata_r[ST_PROT_READ +: 2] <= prot_read_v;
						reg_rdata_r[ST_VERIFY +: 2] <= verify_v;
						reg_rdata_r[ST_BUSY] <= cpu_busy_r;
						reg_rdata_r[ST_HV_PIN] <= high_test_voltage;
						reg_rdata_r[ST_PARKED] <= |parked_v;
					end
					default: reg_rdata_r <= 8'h00;
				endcase
			end
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign cpu_rdata = cpu_rdata_r;
	assign cpu_rvalid = cpu_rvalid_r;
	assign cpu_busy = cpu_busy_r;
	assign mac_addr = mac_addr_r;
	assign mac_margin = mac_margin_r;
	assign upper_drive = drive_v[ARR_UPPER];
	assign lower_drive = drive_v[ARR_LOWER];
endmodule

/* File: design/flash_prot_pkg.sv */
/*
 * Constants, types and layouts shared by the flash page program and
 * protection sequencer. Assumes a two-array flash macro outside the block
 * and software that sequences all program, erase and verify steps itself.
 */
// Overview of operation
// - erased bytes read back as zero
// - program one aligned eight-byte page
// - margin read adds eight cycles
// - margin read only after page programming
// - program select captures page address, data
// - high voltage needs protect byte read
// - protect byte read is latched
// - protected target clears select bit
// - all protect bits erased unlocks all but the protect bytes
// - protect bytes change only with test voltage
// - lowest set bit start governs
// - lower protect byte via upper control
// - wait/stop kills pump, keeps mode bits
// - stop in read mode enters standby
// - high voltage needs select; selects exclusive
// - margin forced zero while high voltage
package flash_prot_pkg;
	localparam int NUM_ARRAYS = 2;
	localparam int ARR_UPPER = 0;
	localparam int ARR_LOWER = 1;

	// register offsets on the plain register port
	localparam logic [2:0] REG_CTRL_UPPER = 3'h0;
	localparam logic [2:0] REG_CTRL_LOWER = 3'h1;
	localparam logic [2:0] REG_STATUS = 3'h2;
	localparam logic [2:0] REG_PROT_UPPER = 3'h3;
	localparam logic [2:0] REG_PROT_LOWER = 3'h4;

	// control register fields
	localparam int BIT_PROG = 0;
	localparam int BIT_ERASE = 1;
	localparam int BIT_MARGIN = 2;
	localparam int BIT_HIGH_VOLTAGE_ENABLE = 3;
	localparam int BIT_BLK = 4;
	localparam int BIT_FDIV = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// status register fields
	localparam int ST_PROT_READ = 0;
	localparam int ST_VERIFY = 2;
	localparam int ST_BUSY = 4;
	localparam int ST_HV_PIN = 5;
	localparam int ST_PARKED = 6;

	// protect byte locations, both inside the upper array
	localparam logic [15:0] PROT_ADDR_UPPER = 16'hff80;
	localparam logic [15:0] PROT_ADDR_LOWER = 16'hff81;
	localparam logic [15:0] PROT_ADDR_INIT = 16'h0000;

	// lock start per protect bit, index is the bit number
	localparam logic [3:0][15:0] UPPER_LOCK = {16'hc000, 16'ha000, 16'h9000, 16'h8000};
	localparam logic [3:0][15:0] LOWER_LOCK = {16'h4000, 16'h2000, 16'h1000, 16'h0450};
	localparam logic [16:0] NO_LOCK = 17'h10000;

	// uncared address bits: erase block by size code, or one page
	localparam logic [3:0][15:0] BLK_MASK = {16'h003f, 16'h01ff, 16'h3fff, 16'h7fff};
	localparam logic [15:0] PAGE_MASK = 16'h0007;
	localparam int PAGE_BYTES = 8;

	localparam int STRETCH_DEFAULT = 8;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_FETCH = 2'b01,
		RD_STRETCH = 2'b10
	} rd_state_type;

	// everything the flash macro of one array needs
	typedef struct packed {
		logic pump_on;
		logic prog;
		logic erase;
		logic margin;
		logic standby;
		logic [1:0] blk;
		logic [1:0] fdiv;
		logic [15:0] target_addr;
		logic [7:0] page_mask;
		logic [63:0] page_data;
	} array_drive_type;
endpackage

/* File: tb/flash_prot_checker_assertions.sv */
/*
 * Concurrent checks on the ports of the flash program and protect sequencer.
 * Assumes clk_en stays high while checks run and one synchronous reset.
 */
`timescale 1ns/1ns
module flash_prot_checker #(
	parameter int STRETCH_CYCLES = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// register and array read side
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic cpu_rd,
	input wire logic cpu_rvalid,
	input wire logic cpu_busy,
	input wire logic mac_margin,
	// power modes and macro control
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire flash_prot_pkg::array_drive_type upper_drive,
	input wire flash_prot_pkg::array_drive_type lower_drive
);
	import flash_prot_pkg::*;
	logic [7:0] busy_cnt_r;

	// length of the read in flight, so latency is checked against the parameter
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !cpu_busy)
			busy_cnt_r <= 8'h00;
		else
			busy_cnt_r <= busy_cnt_r + 8'h01;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// an accepted read and an idle stop, the steps the properties build on
	sequence s_take;
		cpu_rd && !cpu_busy;
	endsequence
	sequence s_stop_idle;
		stop_mode && !upper_drive.prog && !upper_drive.erase;
	endsequence

	a_read_starts: assert property (s_take |=> cpu_busy && !cpu_rvalid)
		else $error("array read did not start");
	a_read_latency: assert property (cpu_rvalid && !$past(sys_rst) |->
		busy_cnt_r == ($past(mac_margin) ? STRETCH_CYCLES + 1 : 1))
		else $error("array read length wrong");
	a_rvalid_single: assert property (cpu_rvalid |=> !cpu_rvalid)
		else $error("read valid longer than one cycle");
	a_busy_end: assert property ($fell(cpu_busy) && !$past(sys_rst) |-> cpu_rvalid)
		else $error("busy dropped without read data");
	a_margin_busy: assert property (mac_margin |-> cpu_busy)
		else $error("margin outside a read");
	a_margin_origin: assert property ($rose(mac_margin) |->
		upper_drive.margin || lower_drive.margin)
		else $error("stretched read without margin select");
	a_rdata_quiet: assert property (!$past(reg_rd) && !$past(sys_rst) |->
		reg_rdata == 8'h00)
		else $error("register data outside read slot");
	a_select_excl: assert property (!(upper_drive.prog && upper_drive.erase) &&
		!(lower_drive.prog && lower_drive.erase))
		else $error("program and erase both selected");
	a_pump_sleep: assert property (wait_mode || stop_mode |=>
		!upper_drive.pump_on && !lower_drive.pump_on)
		else $error("pump running in low power");
	a_standby_on: assert property (s_stop_idle [*2] |=> upper_drive.standby)
		else $error("no standby in stop");
	a_standby_off: assert property (!stop_mode |=> !upper_drive.standby)
		else $error("standby outside stop");
endmodule

bind flash_page_program_protect flash_prot_checker #(.STRETCH_CYCLES(STRETCH_CYCLES)) chk_i (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cpu_rd(cpu_rd), .cpu_rvalid(cpu_rvalid), .cpu_busy(cpu_busy), .mac_margin(mac_margin),
	.wait_mode(wait_mode), .stop_mode(stop_mode), .upper_drive(upper_drive),
	.lower_drive(lower_drive)
);

/* File: tb/tb_top.sv */
/*
 * Self-checking bench for the flash program and protect sequencer.
 * Assumes the package, design and checker are compiled before it.
 */
`timescale 1ns/1ns
module tb_top;
	import flash_prot_pkg::*;
	localparam int STRETCH = 8;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic cpu_wr = 1'b0;
	logic cpu_rd = 1'b0;
	logic high_test_voltage = 1'b0;
	logic wait_mode = 1'b0;
	logic stop_mode = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [15:0] cpu_addr = 16'h0000;
	logic [7:0] cpu_wdata = 8'h00;
	logic [7:0] prot_u = 8'h00;
	logic [7:0] prot_l = 8'h00;
	logic [7:0] reg_rdata, cpu_rdata, mac_rdata, d;
	logic cpu_rvalid, cpu_busy, mac_margin;
	logic [15:0] mac_addr, pg;
	logic [63:0] dat;
	array_drive_type upper_drive, lower_drive;
	int n_fail = 0;
	int total_checks = 0;
	int n;

	flash_page_program_protect #(.STRETCH_CYCLES(STRETCH)) uut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
		.cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_busy(cpu_busy),
		.mac_addr(mac_addr), .mac_margin(mac_margin), .mac_rdata(mac_rdata),
		.high_test_voltage(high_test_voltage), .wait_mode(wait_mode),
		.stop_mode(stop_mode), .upper_drive(upper_drive), .lower_drive(lower_drive)
	);

	initial forever #50 ref_clk = ~ref_clk;

	// macro model: protect bytes at their slots, an address hash elsewhere
	function automatic logic [7:0] fdat(input logic [15:0] a);
		return a == PROT_ADDR_UPPER ? prot_u : a == PROT_ADDR_LOWER ? prot_l : a[7:0] ^ a[15:8];
	endfunction
	always_comb mac_rdata = fdat(mac_addr);

	// locked when the page end reaches the lowest set start, or hits the protect bytes
	function automatic logic viol(input logic up, input logic [3:0] p, input logic [15:0] a,
		input logic hv);
		logic [16:0] st;
		st = NO_LOCK;
		for (int i = 3; i >= 0; i--)
			if (p[i])
				st = {1'b0, up ? UPPER_LOCK[i] : LOWER_LOCK[i]};
		return !hv && ({1'b0, a | 16'h0007} >= st || (up && a[15:3] == 13'h1ff0));
	endfunction

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// bus cycles: strobes released at the taking edge, one idle edge after
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk("register read", reg_rdata, e);
		@(posedge ref_clk);
	endtask
	task automatic cwr(input logic [15:0] a, input logic [7:0] v);
		cpu_addr <= a;
		cpu_wdata <= v;
		cpu_wr <= 1'b1;
		@(posedge ref_clk);
		cpu_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	// array read: n counts edges from take to valid, bounded against a hang
	task automatic crd(input logic [15:0] a);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		@(posedge ref_clk);
		cpu_rd <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (cpu_rvalid !== 1'b1 && n < 40);
		d = cpu_rdata;
		@(posedge ref_clk);
	endtask
	task automatic do_reset;
		sys_rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 0;
		@(posedge ref_clk);
	endtask

	// select, protect read, one write, then try the pump
	task automatic prot_case(input logic up, input logic [7:0] p, input logic [15:0] a,
		input logic hv);
		logic [2:0] r;
		r = up ? REG_CTRL_UPPER : REG_CTRL_LOWER;
		prot_u <= p;
		prot_l <= p;
		high_test_voltage <= hv;
		wr(r, 8'h00);
		// select, protect read, write, high voltage
		// lower protect byte read from upper array
		wr(r, 8'h01);
		crd(up ? PROT_ADDR_UPPER : PROT_ADDR_LOWER);
		rd(up ? REG_PROT_UPPER : REG_PROT_LOWER, p);
		cwr(a, 8'h5a);
		wr(r, 8'h09);
		rd(r, viol(up, p[3:0], a, hv) ? 8'h01 : 8'h09);
		wr(r, 8'h00);
	endtask

	initial begin
		#(20000 * 100);
		n_fail++;
		tally_and_finish;
	end

	initial begin
		void'($urandom(59344));
		do_reset;
		for (int i = 0; i < 8; i++)
			rd(3'(i), 8'h00);
		wr(REG_PROT_UPPER, 8'hff);
		rd(REG_PROT_UPPER, 8'h00);
		wr(REG_CTRL_UPPER, 8'h08);
		rd(REG_CTRL_UPPER, 8'h00);
		wr(REG_CTRL_UPPER, 8'h02);
		wr(REG_CTRL_UPPER, 8'h03);
		rd(REG_CTRL_UPPER, 8'h02);
		wr(REG_CTRL_UPPER, 8'h04);
		for (int i = 0; i < 4; i++) begin
			pg = 16'($urandom);
			crd(pg);
			chk("read length", n, 1);
			chk("read data", d, fdat(pg));
		end
		// full page program, a stray write to the adjacent page, then verify
		// each row is programmed at most once here
		// steps kept in order, no interrupts in this bench
		wr(REG_CTRL_UPPER, 8'h01);
		crd(PROT_ADDR_UPPER);
		pg = 16'h8000 | (16'($urandom) & 16'h3ff8);
		dat = {$urandom, $urandom};
		for (int i = 0; i < 8; i++)
			cwr(pg + 16'(i), dat[8 * i +: 8]);
		cwr(pg ^ 16'h0008, 8'hff);
		#1;
		chk("target", upper_drive.target_addr, pg);
		chk("page mask", upper_drive.page_mask, 8'hff);
		chk("page data", upper_drive.page_data, dat);
		@(posedge ref_clk);
		wr(REG_CTRL_UPPER, 8'h0d);
		rd(REG_CTRL_UPPER, 8'h09);
		chk("pump", upper_drive.pump_on, 1'b1);
		// finish order: high voltage off, margin, program off
		wr(REG_CTRL_UPPER, 8'h01);
		wr(REG_CTRL_UPPER, 8'h05);
		wr(REG_CTRL_UPPER, 8'h04);
		// stretched reads counted against the bench's own budget
		for (int i = 0; i < 8; i++) begin
			crd(pg + 16'(i));
			chk("margin length", n, 1 + STRETCH);
			chk("margin data", d, fdat(pg + 16'(i)));
		end
		wr(REG_CTRL_UPPER, 8'h00);
		// dummy reads before trusting array data
		repeat (500)
			crd(pg);
		chk("read after dummies", d, fdat(pg));
		chk("dummy read length", n, 1);
		// random targets, protect bytes and test voltage, then the corners
		for (int i = 0; i < 12; i++) begin
			pg = 16'($urandom) & 16'hfff8;
			prot_case(pg[15], 8'($urandom), pg, ($urandom % 4) == 0);
		end
		prot_case(1'b1, 8'h00, PROT_ADDR_UPPER, 1'b0);
		prot_case(1'b1, 8'h00, PROT_ADDR_UPPER, 1'b1);
		prot_case(1'b1, 8'h06, 16'h8ff8, 1'b0);
		prot_case(1'b0, 8'h01, 16'h0448, 1'b0);
		prot_case(1'b0, 8'hf0, 16'h7ff8, 1'b0);
		// wait with the pump on parks it until reset, mode bits stay
		high_test_voltage <= 1'b0;
		prot_u <= 8'h00;
		wr(REG_CTRL_UPPER, 8'h01);
		crd(PROT_ADDR_UPPER);
		cwr(16'h8800, 8'h11);
		wr(REG_CTRL_UPPER, 8'h09);
		wait_mode <= 1'b1;
		repeat (3) @(posedge ref_clk);
		wait_mode <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk("pump after wait", upper_drive.pump_on, 1'b0);
		@(posedge ref_clk);
		rd(REG_CTRL_UPPER, 8'h09);
		do_reset;
		stop_mode <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("standby", upper_drive.standby, 1'b1);
		@(posedge ref_clk);
		stop_mode <= 1'b0;
		@(posedge ref_clk);
		tally_and_finish;
	end
endmodule
